// [hdl/tmrps_pkg.sv]
package tmrps_pkg;

   // ----------------------------------------------------------------
   // register map (word index, byte address is index * 4)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_COUNT = 8'h01;
   localparam logic [7:0] OFS_OPTION = 8'h81;
   localparam logic [7:0] OFS_INTCTL = 8'h0b;
   localparam logic [7:0] OFS_WDCTL = 8'h90;
   localparam logic [7:0] OFS_WDSTAT = 8'h91;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int OPT_CS_BIT = 5;
   localparam int OPT_SE_BIT = 4;
   localparam int OPT_PA_BIT = 3;
   localparam int INT_IE_BIT = 5;
   localparam int INT_IF_BIT = 2;
   localparam int WD_CLR_BIT = 0;
   localparam int WD_RUN_BIT = 1;
   localparam int WD_SLEEP_BIT = 2;
   localparam logic [7:0] OPTION_RST = 8'hff;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int PHASES = 4;
   localparam logic [1:0] PH_SECOND = 2'h1;
   localparam logic [1:0] PH_FOURTH = 2'h3;
   localparam int INHIBIT_CYC = 2;
   localparam int PS_WIDTH = 8;
   localparam int WD_DIV_WIDTH = 16;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] unused_hi;
      logic clock_source_select;
      logic source_edge_select;
      logic prescaler_assign;
      logic [2:0] prescale_ratio_field;
   } tmrps_option_t;

   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } tmrps_wb_req_t;

   typedef enum logic [1:0] {
      TMRPS_IDLE,
      TMRPS_ACK
   } tmrps_bus_state_t;

endpackage

// [hdl/tmrps_phase_gen.sv]
`timescale 1ns/10ps
// instruction cycle divider: four phases per instruction cycle, pulses on the second and fourth
module tmrps_phase_gen
(
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   output logic second_phase_clock,
   output logic fourth_phase_clock,
   output logic instr_cycle
);

   logic [1:0] phase_reg;
   logic [1:0] phase_next;

   always_comb
   begin
      phase_next = phase_reg;
      if (run)
      begin
         phase_next = phase_reg + 2'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         phase_reg <= 2'h0;
      end
      else
      begin
         phase_reg <= phase_next;
      end
   end

   assign second_phase_clock = run && (phase_reg == tmrps_pkg::PH_SECOND);
   assign fourth_phase_clock = run && (phase_reg == tmrps_pkg::PH_FOURTH);
   assign instr_cycle = fourth_phase_clock;

endmodule

// [hdl/tmrps_prescaler.sv]
`timescale 1ns/10ps
// shared divider; count is never visible to software
module tmrps_prescaler
#(
   parameter int WIDTH = tmrps_pkg::PS_WIDTH
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic clear,
   input wire logic tick,
   input wire logic [2:0] ratio,
   input wire logic timer_side,
   output logic out_level
);

   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;
   logic [3:0] tap;

   always_comb
   begin
      cnt_next = cnt_reg;
      if (clear)
      begin
         cnt_next = '0;
      end
      else if (tick)
      begin
         cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_reg <= '0;
      end
      else
      begin
         cnt_reg <= cnt_next;
      end
   end

   // timer side divides by 2..256, watchdog side by 1..128
   always_comb
   begin
      tap = {1'b0, ratio};
      if (!timer_side)
      begin
         tap = {1'b0, ratio} - 4'h1;
      end
   end

   assign out_level = (!timer_side && ratio == 3'h0) ? tick : cnt_reg[tap[2:0]];

endmodule

// [hdl/tmrps_timer.sv]
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module tmrps_timer
#(
   parameter int WD_WIDTH = tmrps_pkg::WD_DIV_WIDTH
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_count_input,
   input wire logic sleep,
   output logic overflow_irq,
   output logic watchdog_tick
);

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   tmrps_pkg::tmrps_wb_req_t req;
   tmrps_pkg::tmrps_bus_state_t bus_state_reg;
   tmrps_pkg::tmrps_bus_state_t bus_state_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic take;
   logic wr;
   logic lane0;
   logic hit_count;
   logic hit_option;
   logic hit_intctl;
   logic hit_wdctl;
   logic hit_wdstat;

   assign req = '{adr: wb_adr_i[9:2], dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i, cyc: wb_cyc_i, stb: wb_stb_i};
   assign take = req.cyc && req.stb && (bus_state_reg == tmrps_pkg::TMRPS_IDLE);
   assign lane0 = req.sel[0];
   assign wr = take && req.we && lane0;
   assign hit_count = (req.adr == tmrps_pkg::OFS_COUNT);
   assign hit_option = (req.adr == tmrps_pkg::OFS_OPTION);
   assign hit_intctl = (req.adr == tmrps_pkg::OFS_INTCTL);
   assign hit_wdctl = (req.adr == tmrps_pkg::OFS_WDCTL);
   assign hit_wdstat = (req.adr == tmrps_pkg::OFS_WDSTAT);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   tmrps_pkg::tmrps_option_t option_reg;
   tmrps_pkg::tmrps_option_t option_next;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic overflow_flag_reg;
   logic overflow_flag_next;
   logic overflow_irq_enable_reg;
   logic overflow_irq_enable_next;
   logic wd_run_reg;
   logic wd_run_next;
   logic [1:0] inhibit_reg;
   logic [1:0] inhibit_next;
   logic [WD_WIDTH-1:0] wd_div_reg;
   logic [WD_WIDTH-1:0] wd_div_next;
   logic samp_reg;
   logic samp_next;
   logic samp_prev_reg;
   logic samp_prev_next;

   // ----------------------------------------------------------------
   // phase clocks and source selection
   // ----------------------------------------------------------------
   logic second_phase_clock;
   logic fourth_phase_clock;
   logic instr_cycle;
   logic awake;
   logic timer_owns;
   logic ext_level;
   logic src_tick;
   logic ext_rise;
   logic ps_out;
   logic ps_clear;
   logic ps_tick;
   logic src_level;
   logic edge_seen;
   logic count_write;
   logic wd_clear;
   logic inc;

   assign awake = !sleep;

   tmrps_phase_gen u_phase
   (
      .clk(clk),
      .srst(srst),
      .run(awake),
      .second_phase_clock(second_phase_clock),
      .fourth_phase_clock(fourth_phase_clock),
      .instr_cycle(instr_cycle)
   );

   assign timer_owns = !option_reg.prescaler_assign;
   // edge select: xor turns the falling edge into a rising one
   assign ext_level = external_count_input ^ option_reg.source_edge_select;
   assign count_write = wr && hit_count;
   assign wd_clear = wr && hit_wdctl && req.dat[tmrps_pkg::WD_CLR_BIT];

   // timer source pulse: instruction cycle, or a pin rise (sampled, or raw into the divider)
   assign src_tick = option_reg.clock_source_select ? (timer_owns ? ext_rise : edge_seen) : instr_cycle;
   // watchdog side ticks on its own divider carry
   assign ps_tick = timer_owns ? src_tick : (wd_run_reg && instr_cycle && (&wd_div_reg));
   assign ps_clear = timer_owns ? count_write : wd_clear;

   tmrps_prescaler #(.WIDTH(tmrps_pkg::PS_WIDTH)) u_ps
   (
      .clk(clk),
      .srst(srst),
      .clear(ps_clear),
      .tick(ps_tick),
      .ratio(option_reg.prescale_ratio_field),
      .timer_side(timer_owns),
      .out_level(ps_out)
   );

   // without a prescaler the pin level itself goes to the sampler
   assign src_level = option_reg.prescaler_assign ? ext_level : ps_out;

   // ----------------------------------------------------------------
   // synchroniser: sample on second and fourth phases
   // ----------------------------------------------------------------
   always_comb
   begin
      samp_next = samp_reg;
      samp_prev_next = samp_prev_reg;
      if (second_phase_clock || fourth_phase_clock)
      begin
         samp_next = src_level;
         samp_prev_next = samp_reg;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // high: under the reset edge select a low pin gives no false count
         samp_reg <= 1'b1;
         samp_prev_reg <= 1'b1;
      end
      else
      begin
         samp_reg <= samp_next;
         samp_prev_reg <= samp_prev_next;
      end
   end

   // every sample pair is judged once, so one edge never counts twice
   assign edge_seen = (second_phase_clock || fourth_phase_clock) && samp_reg && !samp_prev_reg;

   // edge detects around the timer-owned divider
   logic ps_prev_reg;
   logic ps_prev_next;
   logic ps_edge;
   logic ext_prev_reg;
   logic ext_prev_next;

   always_comb
   begin
      ps_prev_next = ps_prev_reg;
      ext_prev_next = ext_level;
      if (fourth_phase_clock)
      begin
         ps_prev_next = samp_reg;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ps_prev_reg <= 1'b0;
         ext_prev_reg <= 1'b1;
      end
      else
      begin
         ps_prev_reg <= ps_prev_next;
         ext_prev_reg <= ext_prev_next;
      end
   end

   // divider output toggles twice per ratio; only rising counts
   assign ps_edge = timer_owns && fourth_phase_clock && samp_reg && !ps_prev_reg;
   // counter mode into the divider: raw pin rise, halted in sleep
   assign ext_rise = awake && ext_level && !ext_prev_reg;

   // ----------------------------------------------------------------
   // count, inhibit and overflow
   // ----------------------------------------------------------------
   // in timer mode with no prescaler the sampler is bypassed entirely
   assign inc = (option_reg.prescaler_assign ? src_tick : ps_edge) && awake && (inhibit_reg == 2'h0);

   always_comb
   begin
      count_next = count_reg;
      inhibit_next = inhibit_reg;
      overflow_flag_next = overflow_flag_reg;
      if (instr_cycle && inhibit_reg != 2'h0)
      begin
         inhibit_next = inhibit_reg - 2'h1;
      end
      if (count_write)
      begin
         count_next = req.dat[7:0];
         inhibit_next = 2'(tmrps_pkg::INHIBIT_CYC);
      end
      else if (inc)
      begin
         count_next = count_reg + 8'h01;
      end
      if (wr && hit_intctl)
      begin
         overflow_flag_next = req.dat[tmrps_pkg::INT_IF_BIT];
      end
      // set wins over a simultaneous software clear
      if (!count_write && inc && count_reg == tmrps_pkg::COUNT_MAX)
      begin
         overflow_flag_next = 1'b1;
      end
   end

   always_comb
   begin
      option_next = option_reg;
      overflow_irq_enable_next = overflow_irq_enable_reg;
      wd_run_next = wd_run_reg;
      wd_div_next = wd_div_reg;
      if (wr && hit_option)
      begin
         option_next = req.dat[7:0];
      end
      if (wr && hit_intctl)
      begin
         overflow_irq_enable_next = req.dat[tmrps_pkg::INT_IE_BIT];
      end
      if (wr && hit_wdctl)
      begin
         wd_run_next = req.dat[tmrps_pkg::WD_RUN_BIT];
      end
      if (wd_clear)
      begin
         wd_div_next = '0;
      end
      else if (wd_run_reg && instr_cycle)
      begin
         wd_div_next = wd_div_reg + {{(WD_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         option_reg <= tmrps_pkg::OPTION_RST;
         count_reg <= tmrps_pkg::COUNT_RST;
         inhibit_reg <= 2'h0;
         overflow_flag_reg <= 1'b0;
         overflow_irq_enable_reg <= 1'b0;
         wd_run_reg <= 1'b0;
         wd_div_reg <= '0;
      end
      else
      begin
         option_reg <= option_next;
         count_reg <= count_next;
         inhibit_reg <= inhibit_next;
         overflow_flag_reg <= overflow_flag_next;
         overflow_irq_enable_reg <= overflow_irq_enable_next;
         wd_run_reg <= wd_run_next;
         wd_div_reg <= wd_div_next;
      end
   end

   assign overflow_irq = overflow_flag_reg && overflow_irq_enable_reg;
   // watchdog time base: prescaler output when assigned, else own carry
   assign watchdog_tick = option_reg.prescaler_assign ? ps_out : (wd_run_reg && instr_cycle && (&wd_div_reg));

   // ----------------------------------------------------------------
   // bus slave: one wait state, read data from a register
   // ----------------------------------------------------------------
   always_comb
   begin
      bus_state_next = bus_state_reg;
      rdata_next = rdata_reg;
      unique case (bus_state_reg)
         tmrps_pkg::TMRPS_IDLE:
         begin
            if (take)
            begin
               bus_state_next = tmrps_pkg::TMRPS_ACK;
               rdata_next = 32'h0000_0000;
               if (hit_count)
               begin
                  rdata_next[7:0] = count_reg;
               end
               else if (hit_option)
               begin
                  rdata_next[7:0] = option_reg;
               end
               else if (hit_intctl)
               begin
                  rdata_next[tmrps_pkg::INT_IE_BIT] = overflow_irq_enable_reg;
                  rdata_next[tmrps_pkg::INT_IF_BIT] = overflow_flag_reg;
               end
               else if (hit_wdctl)
               begin
                  rdata_next[tmrps_pkg::WD_RUN_BIT] = wd_run_reg;
               end
               else if (hit_wdstat)
               begin
                  rdata_next[tmrps_pkg::WD_SLEEP_BIT] = sleep;
               end
            end
         end
         tmrps_pkg::TMRPS_ACK:
         begin
            bus_state_next = tmrps_pkg::TMRPS_IDLE;
         end
         default:
         begin
            bus_state_next = tmrps_pkg::TMRPS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bus_state_reg <= tmrps_pkg::TMRPS_IDLE;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
         rdata_reg <= rdata_next;
      end
   end

   assign wb_ack_o = (bus_state_reg == tmrps_pkg::TMRPS_ACK);
   assign wb_dat_o = rdata_reg;

endmodule

// [sim/tmrps_timer_monitor.sv]
`timescale 1ns/10ps
module tmrps_timer_monitor
#(
   parameter int WD_WIDTH = 16
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic external_count_input,
   input wire logic sleep,
   input wire logic overflow_irq,
   input wire logic watchdog_tick
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // ----------------------------------------------------------------
   // bus and flag relations
   // ----------------------------------------------------------------
   a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_idle_quiet: assert property (!wb_cyc_i |=> !wb_ack_o)
      else $error("ack while bus idle");
   a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
      else $error("read data moved outside an access");
   a_flag_sticky: assert property ($fell(overflow_irq) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
      else $error("overflow request dropped without a write");
   a_sleep_still: assert property ((sleep && !overflow_irq && !(wb_cyc_i && wb_stb_i)) [*3] |=> !overflow_irq)
      else $error("overflow raised during sleep");

   c_irq: cover property ($rose(overflow_irq));
   c_write: cover property (wb_ack_o && wb_we_i);
   c_sleep_read: cover property (sleep && wb_ack_o);
endmodule

bind tmrps_timer tmrps_timer_monitor #(.WD_WIDTH(WD_WIDTH)) i_mon(.clk(clk), .srst(srst), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_count_input(external_count_input), .sleep(sleep),
   .overflow_irq(overflow_irq), .watchdog_tick(watchdog_tick));

// [sim/tmrps_pin_src.sv]
`timescale 1ns/10ps
// external count source; idles low between bursts
module tmrps_pin_src
(
   input wire logic clk,
   output logic pin
);
   initial pin = 1'b0;

   // hold of 0 clocks would let the phase sampler miss a level
   task automatic pulses(input int n, input int hold);
      for (int i = 0; i < 2 * n; i++)
      begin
         @(posedge clk);
         pin <= ~pin;
         repeat (hold) @(posedge clk);
      end
   endtask
endmodule

// [sim/test_tmrps_timer.sv]
`timescale 1ns/10ps
module test_tmrps_timer;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dat_o;
   logic [31:0] rdat;
   logic [3:0] sel = 4'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic sleep = 1'b0;
   logic ack;
   logic irq;
   logic pin;
   logic [31:0] seed = 32'h02f1;
   logic [7:0] v0;
   logic [7:0] model_count;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   int w0;
   int wd_rises = 0;
   logic wdt;
   logic wdt_prev = 1'b0;

   always #4 clk = ~clk;

   tmrps_timer #(.WD_WIDTH(4)) i_dut(.clk(clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .external_count_input(pin), .sleep(sleep), .overflow_irq(irq), .watchdog_tick(wdt));
   tmrps_pin_src i_src(.clk(clk), .pin(pin));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic end_of_test;
      if (num_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // take edges of two calls are 4 + idle clocks apart
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h1;
      adr <= {22'h0, idx, 2'b00};
      wdat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         num_errors++;
         end_of_test();
      end
   end

   // watchdog time base rises, counted by nba so readers at the edge agree
   always @(posedge clk)
   begin
      wdt_prev <= wdt;
      if (wdt === 1'b1 && wdt_prev === 1'b0)
         wd_rises <= wd_rises + 1;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      bus(0, tmrps_pkg::OFS_OPTION, 8'h0);
      cmp("option", 32'hff, rdat);
      bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
      cmp("count", 32'h0, rdat);
      bus(0, 8'hff, 8'h0);
      cmp("unmapped", 32'h0, rdat);
      seed = lfsr(seed);
      bus(1, tmrps_pkg::OFS_OPTION, seed[7:0]);
      bus(0, tmrps_pkg::OFS_OPTION, 8'h0);
      cmp("option", {24'h0, seed[7:0]}, rdat);
      // timer mode, prescaler kept on the watchdog side
      bus(1, tmrps_pkg::OFS_OPTION, 8'h08);
      seed = lfsr(seed);
      bus(1, tmrps_pkg::OFS_COUNT, seed[7:0]);
      repeat (37) @(posedge clk);
      bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
      model_count = seed[7:0] + 8'd8;
      cmp("count", {24'h0, model_count}, rdat);
      repeat (76) @(posedge clk);
      bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
      model_count = model_count + 8'd20;
      cmp("count", {24'h0, model_count}, rdat);
      bus(1, tmrps_pkg::OFS_INTCTL, 8'h00);
      bus(1, tmrps_pkg::OFS_COUNT, 8'hfd);
      repeat (40) @(posedge clk);
      cmp("irq", 32'h0, {31'h0, irq});
      bus(0, tmrps_pkg::OFS_INTCTL, 8'h0);
      cmp("intctl", 32'h04, rdat);
      bus(1, tmrps_pkg::OFS_INTCTL, 8'h24);
      cmp("irq", 32'h1, {31'h0, irq});
      bus(1, tmrps_pkg::OFS_INTCTL, 8'h20);
      cmp("irq", 32'h0, {31'h0, irq});
      @(posedge clk);
      sleep <= 1'b1;
      bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
      v0 = rdat[7:0];
      bus(0, tmrps_pkg::OFS_WDSTAT, 8'h0);
      cmp("status", 32'h04, rdat);
      repeat (40) @(posedge clk);
      bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
      cmp("sleep count", {24'h0, v0}, rdat);
      sleep <= 1'b0;
      bus(1, 8'h90, 8'h01);
      for (int r = 0; r < 8; r++)
      begin
         bus(1, tmrps_pkg::OFS_OPTION, r[7:0]);
         bus(1, tmrps_pkg::OFS_COUNT, 8'h0);
         // let the two inhibited instruction cycles pass before the window opens
         repeat (8) @(posedge clk);
         bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
         model_count = rdat[7:0] + 8'd2;
         repeat ((16 << r) - 4) @(posedge clk);
         bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
         cmp("scaled count", {24'h0, model_count}, rdat);
      end
      for (int e = 0; e < 2; e++)
      begin
         bus(1, tmrps_pkg::OFS_OPTION, 8'h28 | (e[7:0] << 4));
         repeat (16) @(posedge clk);
         bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
         seed = lfsr(seed);
         n = 1 + seed[2:0];
         model_count = rdat[7:0] + n[7:0];
         i_src.pulses(n, 8 + seed[6:4]);
         repeat (16) @(posedge clk);
         bus(0, tmrps_pkg::OFS_COUNT, 8'h0);
         cmp("edge count", {24'h0, model_count}, rdat);
      end
      // watchdog runs, prescaler on its side at 1:2 over a 16-instruction carry
      bus(1, tmrps_pkg::OFS_WDCTL, 8'h03);
      bus(1, tmrps_pkg::OFS_OPTION, 8'h09);
      w0 = wd_rises;
      repeat (1024) @(posedge clk);
      // one rise per 2 * 16 * 4 clocks
      cmp("watchdog ticks", 32'h8, wd_rises - w0);
      end_of_test();
   end
endmodule
